// file: rtl/vofs_core.sv
`timescale 1ns/1ps
module vofs_core
    import vofs_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pixel stream in, same clock
    input  wire logic        pix_valid,
    input  wire vofs_pix_t   pix_in,
    input  wire logic        digital_sel,
    input  wire logic        dig_hsync,
    input  wire logic        dig_vsync,
    // analog-side pins
    input  wire logic        hsync_pin,
    input  wire logic        vsync_pin,
    input  wire logic        hold_pin,
    input  wire logic        ext_clamp_pin,
    // output ports
    output vofs_pix_t        port_a,
    output vofs_pix_t        port_b,
    output logic             port_a_oe,
    output logic             port_b_oe,
    output logic             port_update,
    output logic             output_data_clock,
    // syncs out
    output logic             hsync_out,
    output logic             sync_on_green,
    output logic             vsync_out,
    // clock generator and clamp control
    output logic             gen_hold,
    output logic             loop_hsync_ref,
    output logic             pixel_clock_source_select,
    output logic             clamp_active,
    output logic [2:0]       clamp_midscale
);

    vofs_state_t st_q;
    vofs_state_t st_d;

    logic       hit;
    logic [5:0] idx;
    logic       dual;
    logic       pairing;
    logic       phase;
    logic       hs_lvl;
    logic       hs_act;
    logic       hs_act_prev;
    logic       lead;
    logic       trail;
    logic       first;
    logic       to_b;

    function automatic logic [7:0] at_least_one(input logic [7:0] v);
        return (v == 8'h00) ? 8'h01 : v;
    endfunction : at_least_one

    function automatic logic [7:0] reg_read(input vofs_state_t s, input logic [5:0] i);
        unique case (i)
            IDX_CLAMP_PLACE: reg_read = s.place_q;
            IDX_CLAMP_LEN:   reg_read = s.len_q;
            IDX_OUT_MODE:    reg_read = s.out_mode_q;
            IDX_SYNC_CLAMP:  reg_read = s.sync_clamp_q;
            IDX_OUT_CLOCK:   reg_read = s.out_clock_q;
            default:         reg_read = {2'h0, s.cst, s.clamp_on, s.hold_act, s.odd, s.hs_s[1]};
        endcase
    endfunction : reg_read

    // ****************************************
    // apb decode
    // ****************************************
    always_comb begin
        idx = paddr[7:2];
        hit = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0) &&
              (idx == IDX_CLAMP_PLACE || idx == IDX_CLAMP_LEN || idx == IDX_OUT_MODE ||
               idx == IDX_SYNC_CLAMP || idx == IDX_OUT_CLOCK || idx == IDX_STATUS);
    end

    // zero-wait slave: answer in the first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = st_q.rdata_q;

    // ****************************************
    // sync and steering decode
    // ****************************************
    always_comb begin
        dual    = digital_sel ? st_q.out_clock_q[B_PIX_PER_CLK] : st_q.out_mode_q[B_PORT_SPLIT];
        pairing = dual && st_q.out_mode_q[B_PAIRING];
        phase   = dual && st_q.out_mode_q[B_PORT_PHASE];
        hs_lvl  = digital_sel ? dig_hsync : st_q.hs_s[1];
        hs_act      = digital_sel ? hs_lvl : (st_q.sync_clamp_q[B_HS_IN_LVL] ? hs_lvl : !hs_lvl);
        hs_act_prev = digital_sel ? st_q.hs_prev
                                  : (st_q.sync_clamp_q[B_HS_IN_LVL] ? st_q.hs_prev : !st_q.hs_prev);
        lead    = hs_act && !hs_act_prev;
        trail   = !hs_act && hs_act_prev;
        first   = lead || !st_q.odd;
        to_b    = dual && (first ? phase : !phase);
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_d = st_q;

        // register writes
        if (psel && penable && pwrite && hit && pstrb[0]) begin
            unique case (idx)
                IDX_CLAMP_PLACE: st_d.place_q      = pwdata[7:0];
                IDX_CLAMP_LEN:   st_d.len_q        = pwdata[7:0];
                IDX_OUT_MODE:    st_d.out_mode_q   = {pwdata[7:3], 3'h0};
                IDX_SYNC_CLAMP:  st_d.sync_clamp_q = pwdata[7:0];
                IDX_OUT_CLOCK:   st_d.out_clock_q  = {pwdata[7:2], 2'h0};
                default:         st_d.out_clock_q  = st_q.out_clock_q;
            endcase
        end
        // read data captured in setup so it leaves a flop
        if (psel && !penable) begin
            st_d.rdata_q = hit ? {24'h000000, reg_read(st_q, idx)} : 32'h00000000;
        end

        // pin synchronisers
        st_d.hs_s    = {st_q.hs_s[0], hsync_pin};
        st_d.vs_s    = {st_q.vs_s[0], vsync_pin};
        st_d.hold_s  = {st_q.hold_s[0], hold_pin};
        st_d.clamp_s = {st_q.clamp_s[0], ext_clamp_pin};
        st_d.hs_prev = hs_lvl;

        st_d.pb_oe = dual;
        st_d.upd   = 1'b0;
        if (lead) begin
            st_d.odd = 1'b0;
        end
        if (pix_valid) begin
            st_d.odd = first;
            if (!dual) begin
                st_d.pa  = pix_in;
                st_d.upd = 1'b1;
            end else if (!pairing) begin
                if (to_b) begin
                    st_d.pb = pix_in;
                end else begin
                    st_d.pa = pix_in;
                end
                st_d.upd = 1'b1;
            end else if (first) begin
                st_d.held = pix_in;
            end else begin
                st_d.pa  = phase ? pix_in : st_q.held;
                st_d.pb  = phase ? st_q.held : pix_in;
                st_d.upd = 1'b1;
            end
        end

        st_d.hs_out = st_q.out_mode_q[B_HS_OUT_POL] ? !hs_act : hs_act;
        st_d.vs_out = st_q.out_mode_q[B_VS_OUT_INV] ? (digital_sel ? dig_vsync : st_q.vs_s[1])
                                                    : !(digital_sel ? dig_vsync : st_q.vs_s[1]);

        st_d.hold_act = st_q.sync_clamp_q[B_HOLD_LVL] ? st_q.hold_s[1] : !st_q.hold_s[1];
        // loop reference only when loop clocks
        st_d.loop_ref = lead && !digital_sel && !st_d.hold_act && !st_q.sync_clamp_q[B_PCLK_SRC];

        unique case (st_q.cst)
            CL_IDLE: begin
                if (trail) begin
                    st_d.cst  = CL_WAIT;
                    st_d.ccnt = at_least_one(st_q.place_q);
                end
            end
            CL_WAIT: begin
                if (pix_valid) begin
                    st_d.ccnt = st_q.ccnt - 8'h01;
                    if (st_q.ccnt == 8'h01) begin
                        st_d.cst  = CL_ON;
                        st_d.ccnt = at_least_one(st_q.len_q);
                    end
                end
            end
            CL_ON: begin
                if (pix_valid) begin
                    st_d.ccnt = st_q.ccnt - 8'h01;
                    if (st_q.ccnt == 8'h01) begin
                        st_d.cst = CL_IDLE;
                    end
                end
            end
        endcase
        // restart at every trailing edge, no stale count
        if (trail) begin
            st_d.cst  = CL_WAIT;
            st_d.ccnt = at_least_one(st_q.place_q);
        end
        if (st_q.sync_clamp_q[B_CLAMP_SRC]) begin
            st_d.clamp_on = st_q.sync_clamp_q[B_EXT_CLAMP_LV] ? !st_q.clamp_s[1] : st_q.clamp_s[1];
        end else begin
            st_d.clamp_on = (st_d.cst == CL_ON);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q              <= '0;
            st_q.out_mode_q   <= RST_OUT_MODE;
            st_q.sync_clamp_q <= RST_SYNC_CLAMP;
            st_q.out_clock_q  <= RST_OUT_CLOCK;
            st_q.place_q      <= RST_CLAMP_PLACE;
            st_q.len_q        <= RST_CLAMP_LEN;
            st_q.cst          <= CL_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign port_a        = st_q.pa;
    assign port_b        = st_q.pb;
    assign port_a_oe     = 1'b1;
    assign port_b_oe     = st_q.pb_oe;
    assign port_update   = st_q.upd;
    // clock low at launch, invert digital only
    assign output_data_clock = !st_q.upd ^ (digital_sel && st_q.out_clock_q[B_CLK_INV]);
    assign hsync_out     = st_q.hs_out;
    assign sync_on_green = st_q.hs_out;
    assign vsync_out     = st_q.vs_out;
    assign gen_hold      = st_q.hold_act;
    assign loop_hsync_ref = st_q.loop_ref;
    assign pixel_clock_source_select = st_q.sync_clamp_q[B_PCLK_SRC];
    assign clamp_active  = st_q.clamp_on;
    assign clamp_midscale = st_q.sync_clamp_q[B_CLAMP_REF_HI:0];

    // ****************************************
    // assertions
    // ****************************************
    property p_single_b_off;
        @(posedge clock) disable iff (rst) !dual |=> !port_b_oe;
    endproperty
    a_single_b_off: assert property (p_single_b_off) else $error("port b driven in single mode");

    property p_single_on_a;
        @(posedge clock) disable iff (rst) (pix_valid && !dual) |=> (port_update && port_a == $past(pix_in));
    endproperty
    a_single_on_a: assert property (p_single_on_a) else $error("single pixel not on a");

    property p_first_a;
        @(posedge clock) disable iff (rst)
            (pix_valid && dual && !pairing && !phase && (lead || !st_q.odd)) |=> port_a == $past(pix_in);
    endproperty
    a_first_a: assert property (p_first_a) else $error("first sample missed port a");

    property p_first_b;
        @(posedge clock) disable iff (rst)
            (pix_valid && dual && !pairing && phase && (lead || !st_q.odd)) |=> port_b == $past(pix_in);
    endproperty
    a_first_b: assert property (p_first_b) else $error("first sample missed port b");

    property p_pair_wait;
        @(posedge clock) disable iff (rst)
            (pix_valid && pairing && st_q.odd && !lead) |=> port_update;
    endproperty
    a_pair_wait: assert property (p_pair_wait) else $error("pair not updated on second");

    property p_pair_first_quiet;
        @(posedge clock) disable iff (rst) (pix_valid && pairing && (lead || !st_q.odd)) |=> !port_update;
    endproperty
    a_pair_first_quiet: assert property (p_pair_first_quiet) else $error("pair updated early");

    property p_sog_match;
        @(posedge clock) disable iff (rst)
            $past(digital_sel) |-> sync_on_green == ($past(st_q.out_mode_q[B_HS_OUT_POL]) ^ $past(dig_hsync));
    endproperty
    a_sog_match: assert property (p_sog_match) else $error("sog polarity differs");

    property p_vsync_pol;
        @(posedge clock) disable iff (rst)
            ($past(!digital_sel) && $past(!digital_sel, 2) && $past(!digital_sel, 3)) |->
            vsync_out == ($past(st_q.out_mode_q[B_VS_OUT_INV]) ? $past(vsync_pin, 3) : !$past(vsync_pin, 3));
    endproperty
    a_vsync_pol: assert property (p_vsync_pol) else $error("vsync invert wrong");

    property p_ext_clamp;
        @(posedge clock) disable iff (rst)
            ($past(st_q.sync_clamp_q[B_CLAMP_SRC]) && $stable(st_q.sync_clamp_q)) |->
            clamp_active == ($past(st_q.sync_clamp_q[B_EXT_CLAMP_LV]) ? !$past(ext_clamp_pin, 3)
                                                                     : $past(ext_clamp_pin, 3));
    endproperty
    a_ext_clamp: assert property (p_ext_clamp) else $error("external clamp level wrong");

    property p_hold_gates;
        @(posedge clock) disable iff (rst) gen_hold |-> !loop_hsync_ref;
    endproperty
    a_hold_gates: assert property (p_hold_gates) else $error("loop fed during hold");

    property p_ext_clk_no_ref;
        @(posedge clock) disable iff (rst) $past(pixel_clock_source_select) |-> !loop_hsync_ref;
    endproperty
    a_ext_clk_no_ref: assert property (p_ext_clk_no_ref) else $error("loop fed on external clock");

    property p_int_clamp_start;
        @(posedge clock) disable iff (rst)
            (!$past(st_q.sync_clamp_q[B_CLAMP_SRC]) && !$past(st_q.sync_clamp_q[B_CLAMP_SRC], 2) &&
             $rose(clamp_active)) |-> $past(st_q.cst) == CL_WAIT;
    endproperty
    a_int_clamp_start: assert property (p_int_clamp_start) else $error("clamp began without wait");

    c_dual_pair:  cover property (@(posedge clock) disable iff (rst) pairing && port_update);
    c_ext_clamp:  cover property (@(posedge clock) disable iff (rst) st_q.sync_clamp_q[B_CLAMP_SRC] && clamp_active);
    c_int_clamp:  cover property (@(posedge clock) disable iff (rst) st_q.cst == CL_ON);
    c_phase_swap: cover property (@(posedge clock) disable iff (rst) pix_valid && dual && phase);

endmodule : vofs_core

// file: rtl/vofs_pkg.sv
package vofs_pkg;

    // ****************************************
    // register map (index, byte address = 4 * index)
    // ****************************************
    localparam logic [5:0] IDX_CLAMP_PLACE  = 6'h05;
    localparam logic [5:0] IDX_CLAMP_LEN    = 6'h06;
    localparam logic [5:0] IDX_OUT_MODE     = 6'h0E;
    localparam logic [5:0] IDX_SYNC_CLAMP   = 6'h0F;
    localparam logic [5:0] IDX_OUT_CLOCK    = 6'h10;
    localparam logic [5:0] IDX_STATUS       = 6'h1F;

    localparam logic [7:0] RST_CLAMP_PLACE  = 8'h08;
    localparam logic [7:0] RST_CLAMP_LEN    = 8'h14;
    localparam logic [7:0] RST_OUT_MODE     = 8'hD8;
    localparam logic [7:0] RST_SYNC_CLAMP   = 8'hD0;
    localparam logic [7:0] RST_OUT_CLOCK    = 8'h30;

    // ****************************************
    // field positions
    // ****************************************
    localparam int B_PORT_SPLIT   = 7;
    localparam int B_PAIRING      = 6;
    localparam int B_PORT_PHASE   = 5;
    localparam int B_HS_OUT_POL   = 4;
    localparam int B_VS_OUT_INV   = 3;
    localparam int B_HS_IN_LVL    = 7;
    localparam int B_HOLD_LVL     = 6;
    localparam int B_CLAMP_SRC    = 5;
    localparam int B_EXT_CLAMP_LV = 4;
    localparam int B_PCLK_SRC     = 3;
    localparam int B_CLAMP_REF_HI = 2;
    localparam int B_CLK_INV      = 7;
    localparam int B_PIX_PER_CLK  = 6;

    localparam int CH_W = 8;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [CH_W-1:0] r;
        logic [CH_W-1:0] g;
        logic [CH_W-1:0] b;
    } vofs_pix_t;

    typedef enum logic [1:0] {CL_IDLE, CL_WAIT, CL_ON} vofs_clamp_st_t;

    typedef struct packed {
        logic [7:0]     out_mode_q;
        logic [7:0]     sync_clamp_q;
        logic [7:0]     out_clock_q;
        logic [7:0]     place_q;
        logic [7:0]     len_q;
        logic [31:0]    rdata_q;
        logic [1:0]     hs_s;
        logic [1:0]     vs_s;
        logic [1:0]     hold_s;
        logic [1:0]     clamp_s;
        logic           hs_prev;
        logic           odd;
        vofs_pix_t      held;
        vofs_pix_t      pa;
        vofs_pix_t      pb;
        logic           pb_oe;
        logic           upd;
        logic           hs_out;
        logic           vs_out;
        logic           hold_act;
        logic           loop_ref;
        logic           clamp_on;
        logic [7:0]     ccnt;
        vofs_clamp_st_t cst;
    } vofs_state_t;

endpackage : vofs_pkg

// file: test/vofs_sink.sv
`timescale 1ns/1ps
// ****
// downstream capture model
// ****
module vofs_sink
    import vofs_pkg::*;
(
    // data clock from the block
    input wire logic      output_data_clock,
    input wire logic      inv,
    // pixel ports
    input wire vofs_pix_t port_a,
    input wire vofs_pix_t port_b
);
    vofs_pix_t qa[$];
    vofs_pix_t qb[$];
    // inverted clock undone here, a missing launch edge loses a sample
    wire       ck = output_data_clock ^ inv;

    always @(posedge ck) begin
        qa.push_back(port_a);
        qb.push_back(port_b);
    end
endmodule : vofs_sink

// file: test/video_output_format_sync_control_tb.sv
`timescale 1ns/1ps
module video_output_format_sync_control_tb;
    import vofs_pkg::*;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, pix_valid;
    logic        digital_sel, dig_hsync, dig_vsync, hsync_pin, vsync_pin, hold_pin;
    logic        ext_clamp_pin, port_a_oe, port_b_oe, port_update, output_data_clock;
    logic        hsync_out, sync_on_green, vsync_out, gen_hold, loop_hsync_ref;
    logic        pixel_clock_source_select, clamp_active, inv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [2:0]  clamp_midscale;
    logic [7:0]  pv;
    vofs_pix_t   pix_in, port_a, port_b;
    vofs_pix_t   px[4];
    int          failures, checked, cyc, nref, nupd;

    vofs_core dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .pix_valid, .pix_in, .digital_sel, .dig_hsync, .dig_vsync, .hsync_pin, .vsync_pin,
        .hold_pin, .ext_clamp_pin, .port_a, .port_b, .port_a_oe, .port_b_oe, .port_update,
        .output_data_clock, .hsync_out, .sync_on_green, .vsync_out, .gen_hold, .loop_hsync_ref,
        .pixel_clock_source_select, .clamp_active, .clamp_midscale);
    vofs_sink sink (.output_data_clock, .inv, .port_a, .port_b);

    always #2.5 clock = ~clock;

    // ****
    // shared tasks
    // ****
    task automatic end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // ceiling well above the roughly 750 cycles the run needs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (loop_hsync_ref === 1'b1) nref <= nref + 1;
        if (port_update === 1'b1) nupd <= nupd + 1;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt

    task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1; pwrite <= w; paddr <= {4'h0, i, 2'b00}; pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        // only the bench timeout ends a stuck wait
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, i, d, r, e);
    endtask : wr

    task automatic rdc(input string nm, input logic [5:0] i, input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, i, 8'h00, r, e);
        chk(nm, r, {24'h0, x});
    endtask : rdc

    // one line: leading edge, n pixels, trailing edge
    task automatic line(input int n);
        @(posedge clock); hsync_pin <= 1'b1; dig_hsync <= 1'b1;
        wt(5);
        for (int k = 0; k < n; k++) begin
            px[k] = {pv, 8'h3C, ~pv};
            pv++;
            pix_in <= px[k]; pix_valid <= 1'b1;
            @(posedge clock); pix_valid <= 1'b0;
            wt(2);
        end
        hsync_pin <= 1'b0; dig_hsync <= 1'b0;
        wt(5);
    endtask : line

    // ****
    // scenarios
    // ****
    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rdc("mode", IDX_OUT_MODE, 8'hD8);
        rdc("sync", IDX_SYNC_CLAMP, 8'hD0);
        rdc("oclk", IDX_OUT_CLOCK, 8'h30);
        rdc("place", IDX_CLAMP_PLACE, 8'h08);
        rdc("len", IDX_CLAMP_LEN, 8'h14);
        apb(1'b0, 6'h3E, 8'h00, r, e);
        chk("slverr", e, 1);
    endtask : t_regs

    task automatic t_syncs;
        for (int m = 0; m < 8; m++) begin
            wr(IDX_OUT_MODE, {3'b110, m[0], m[1], 3'b000});
            digital_sel <= m[2];
            for (int s = 0; s < 2; s++) begin
                @(posedge clock);
                hsync_pin <= s[0]; vsync_pin <= s[0]; dig_hsync <= s[0]; dig_vsync <= s[0];
                wt(5);
                chk("hs", hsync_out, s[0] ^ m[0]);
                chk("sog", sync_on_green, s[0] ^ m[0]);
                chk("vs", vsync_out, s[0] ^ !m[1]);
            end
        end
        @(posedge clock); hsync_pin <= 1'b0; dig_hsync <= 1'b0; digital_sel <= 1'b0;
        wt(5);
    endtask : t_syncs

    // software sets the input level; the pin always pulses high, so level 0 makes the fall the leading edge
    task automatic t_edge(input logic lv, hl, hd, sc, input int er, ef);
        int n0;
        wr(IDX_SYNC_CLAMP, {lv, hl, 2'b01, sc, 3'b000});
        @(posedge clock); hold_pin <= hd;
        wt(5);
        chk("hold", gen_hold, hd == hl);
        chk("src", pixel_clock_source_select, sc);
        n0 = nref;
        @(posedge clock); hsync_pin <= 1'b1;
        wt(8);
        chk("rise", nref - n0, er);
        n0 = nref;
        @(posedge clock); hsync_pin <= 1'b0;
        wt(8);
        chk("fall", nref - n0, ef);
        hold_pin <= 1'b0;
    endtask : t_edge

    task automatic t_clamp;
        int pre, dur;
        pre = 0;
        dur = 0;
        wr(IDX_CLAMP_PLACE, 8'h02);
        wr(IDX_CLAMP_LEN, 8'h03);
        rdc("place", IDX_CLAMP_PLACE, 8'h02);
        wr(IDX_SYNC_CLAMP, 8'hD0);
        line(0);
        for (int k = 0; k < 8; k++) begin
            @(posedge clock); pix_valid <= 1'b1;
            // look mid-cycle: state before this strobe clamps this pixel
            @(negedge clock);
            if (clamp_active === 1'b1) dur++;
            else if (dur == 0) pre++;
            @(posedge clock); pix_valid <= 1'b0;
            wt(2);
        end
        chk("pre", pre, 2);
        chk("dur", dur, 3);
        for (int l = 0; l < 2; l++)
            for (int p = 0; p < 2; p++) begin
                wr(IDX_SYNC_CLAMP, {3'b111, l[0], 4'b0101});
                @(posedge clock); ext_clamp_pin <= p[0];
                wt(5);
                chk("ext", clamp_active, p[0] ^ l[0]);
                chk("mid", clamp_midscale, 3'b101);
            end
        ext_clamp_pin <= 1'b0;
        wr(IDX_SYNC_CLAMP, 8'hD0);
    endtask : t_clamp

    task automatic t_port(input logic sp, pr, ph, dg);
        int ne, n0;
        wr(IDX_OUT_MODE, {sp, pr, ph, 5'b11000});
        // invert always set: analog source must ignore it
        wr(IDX_OUT_CLOCK, {1'b1, sp, 6'h00});
        @(posedge clock); digital_sel <= dg; inv <= dg;
        line(3);
        sink.qa.delete();
        sink.qb.delete();
        n0 = nupd;
        line(4);
        ne = (sp && pr) ? 2 : 4;
        chk("b_oe", port_b_oe, sp);
        chk("a_oe", port_a_oe, 1);
        chk("upd", nupd - n0, ne);
        chk("ck_idle", output_data_clock, !dg);
        chk("n_upd", sink.qa.size(), ne);
        for (int j = 0; j < ne; j++) begin
            if (!sp) chk("single", sink.qa[j], px[j]);
            else if (!pr) chk("ilv", (j[0] == ph) ? sink.qa[j] : sink.qb[j], px[j]);
            else begin
                chk("pr0", ph ? sink.qb[j] : sink.qa[j], px[2*j]);
                chk("pr1", ph ? sink.qa[j] : sink.qb[j], px[2*j+1]);
            end
        end
    endtask : t_port

    initial begin
        clock = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        pstrb = 4'hF; pix_valid = 0; pix_in = 0; digital_sel = 0; dig_hsync = 0; dig_vsync = 0;
        hsync_pin = 0; vsync_pin = 0; hold_pin = 0; ext_clamp_pin = 0; inv = 0; pv = 8'h10;
        failures = 0; checked = 0; cyc = 0; nref = 0; nupd = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_syncs();
        t_edge(1, 1, 0, 0, 1, 0);
        t_edge(0, 1, 0, 0, 0, 1);
        t_edge(1, 1, 1, 0, 0, 0);
        t_edge(1, 0, 0, 0, 0, 0);
        t_edge(1, 1, 0, 1, 0, 0);
        t_clamp();
        t_port(0, 1, 1, 0);
        t_port(1, 0, 0, 0);
        t_port(1, 0, 1, 0);
        t_port(1, 1, 0, 0);
        t_port(1, 1, 1, 0);
        t_port(0, 0, 0, 1);
        t_port(1, 0, 0, 1);
        end_of_test();
    end
endmodule : video_output_format_sync_control_tb
